// *** shared/mmpc_pkg.sv ***
// Constants, field layout and types for the MII management port control block
package mmpc_pkg;
  // Register map (word index on the plain register port)
  localparam int REG_ADDR_W = 4;
  localparam logic [3:0] ADDR_CONTROL_STATUS = 4'h0;
  localparam logic [3:0] ADDR_TARGET_SELECT = 4'h1;
  localparam logic [3:0] ADDR_MGMT_DATA = 4'h2;
  // Field positions in mii_control_status
  localparam int POS_BUSY = 31;
  localparam int POS_IDLE_LEVEL = 14;
  localparam int POS_RATE_LO = 12;
  localparam int POS_PHY_RESET = 6;
  localparam int POS_AUTONEG = 5;
  localparam int POS_DUPLEX = 4;
  localparam int POS_SPEED = 3;
  localparam int POS_LOOPBACK = 1;
  // Field positions in mii_target_select
  localparam int POS_PORT_LO = 5;
  localparam int POS_REGNUM_LO = 0;
  // Reset values
  localparam logic [1:0] RST_RATE = 2'h0;
  localparam logic RST_BIT = 1'b0;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // Timing: clock and management clock maxima in kHz
  localparam int CLK_KHZ = 100000;
  localparam int MDC_KHZ_RATE0 = 2500;
  localparam int MDC_KHZ_RATE1 = 5000;
  localparam int MDC_KHZ_RATE2 = 10000;
  // Half period in cycles, rounded up so the clock never exceeds its maximum
  function automatic int half_cycles(input int khz);
    return (CLK_KHZ + 2 * khz - 1) / (2 * khz);
  endfunction
  localparam logic [5:0] HALF_RATE0 = 6'(half_cycles(MDC_KHZ_RATE0));
  localparam logic [5:0] HALF_RATE1 = 6'(half_cycles(MDC_KHZ_RATE1));
  localparam logic [5:0] HALF_RATE2 = 6'(half_cycles(MDC_KHZ_RATE2));
  // Management frame layout
  localparam logic [5:0] LAST_FRAME_BIT = 6'h3F;
  localparam logic [5:0] DRIVE_BITS_READ = 6'h2E;
  localparam logic [5:0] DATA_FIRST_BIT = 6'h30;
  localparam logic [31:0] PREAMBLE = 32'hFFFF_FFFF;
  localparam logic [1:0] FRAME_START = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] TA_WRITE = 2'h2;
  // PHY control register words for the setup frames
  localparam logic [4:0] PHY_CTRL_REG = 5'h00;
  localparam logic [15:0] CTRL_RESET_WORD = 16'h8000;
  localparam logic [15:0] CTRL_AUTONEG_WORD = 16'h1000;
  localparam int CTRL_SPEED_BIT = 13;
  localparam int CTRL_DUPLEX_BIT = 8;
  // Setup frame sequence after reset
  typedef enum logic [1:0] {
    SU_IDLE = 2'b00,
    SU_RESET = 2'b01,
    SU_MODE = 2'b10
  } mmpc_setup_e;
endpackage

// *** shared/mmpc_mgmt_if.sv ***
// Link between the register block and the management frame engine
`timescale 1ns/1ps
interface mmpc_mgmt_if;
  logic start; // One-cycle frame launch
  logic isRead; // Frame is a read
  logic [4:0] portNum; // PHY address field
  logic [4:0] regNum; // Register address field
  logic [15:0] wrWord; // Write data field
  logic [1:0] rate; // Management clock rate code
  logic mdioIn; // Synchronised data pin level
  logic done; // One-cycle frame end
  logic [15:0] rdWord; // Word shifted in by a read
  logic mdc; // Management clock pin
  logic mdioOut; // Data pin drive value
  logic mdioOe; // Data pin drive enable
  modport ctrl (output start, isRead, portNum, regNum, wrWord, rate, mdioIn,
    input done, rdWord, mdc, mdioOut, mdioOe);
  modport eng (input start, isRead, portNum, regNum, wrWord, rate, mdioIn,
    output done, rdWord, mdc, mdioOut, mdioOe);
endinterface

// *** hw/mmpc_frame_engine.sv ***
// Management frame engine: clock divider, frame shifter and read capture
`timescale 1ns/1ps
module mmpc_frame_engine
  import mmpc_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  mmpc_mgmt_if.eng mgmt
);

  //////////////////////
  // State
  typedef struct packed {
    logic active; // Frame in progress
    logic phase; // Low half (0) or high half (1) of a bit
    logic readOp; // Current frame is a read
    logic [5:0] bitIdx; // Bit being sent
    logic [5:0] halfCnt; // Cycles into the current half
    logic [63:0] shift; // Frame bits, MSB first
    logic [15:0] rdWord; // Captured read data
    logic done; // Frame end pulse
    logic mdc; // Clock pin
    logic mdioOut; // Data pin value
    logic mdioOe; // Data pin enable
  } mmpc_eng_s;

  mmpc_eng_s s_reg; // Registered state
  mmpc_eng_s s_next; // Next state

  // Half period per rate; reserved code runs slowest
  function automatic logic [5:0] half_limit(input logic [1:0] rate);
    case (rate)
      2'h1: return HALF_RATE1;
      2'h2: return HALF_RATE2;
      default: return HALF_RATE0;
    endcase
  endfunction

  //////////////////////
  // Next-state logic
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (reset) begin
      s_next = '0;
      s_next.mdioOut = 1'b1;
    end else if (!s_reg.active) begin
      // Idle: release the pin so its quiescent level can be watched
      s_next.mdc = 1'b0;
      s_next.mdioOe = 1'b0;
      s_next.mdioOut = 1'b1;
      if (mgmt.start) begin
        s_next.active = 1'b1;
        s_next.readOp = mgmt.isRead;
        s_next.bitIdx = '0;
        s_next.halfCnt = '0;
        s_next.phase = 1'b0;
        s_next.shift = {PREAMBLE, FRAME_START, mgmt.isRead ? OP_READ : OP_WRITE,
          mgmt.portNum, mgmt.regNum, mgmt.isRead ? 2'h3 : TA_WRITE,
          mgmt.isRead ? 16'hFFFF : mgmt.wrWord};
        s_next.mdioOut = 1'b1;
        s_next.mdioOe = 1'b1;
      end
    end else if (s_reg.halfCnt == half_limit(mgmt.rate) - 6'd1) begin
      s_next.halfCnt = '0;
      if (!s_reg.phase) begin
        // Rising edge: read data taken here
        s_next.phase = 1'b1;
        s_next.mdc = 1'b1;
        if (s_reg.readOp && s_reg.bitIdx >= DATA_FIRST_BIT) begin
          s_next.rdWord = {s_reg.rdWord[14:0], mgmt.mdioIn};
        end
      end else begin
        // Falling edge: next bit or finish
        s_next.phase = 1'b0;
        s_next.mdc = 1'b0;
        if (s_reg.bitIdx == LAST_FRAME_BIT) begin
          s_next.active = 1'b0;
          s_next.done = 1'b1;
          s_next.mdioOe = 1'b0;
          s_next.mdioOut = 1'b1;
        end else begin
          s_next.bitIdx = s_reg.bitIdx + 6'd1;
          s_next.shift = {s_reg.shift[62:0], 1'b0};
          s_next.mdioOut = s_reg.shift[62];
          // Reads release the pin from turnaround on
          s_next.mdioOe = !s_reg.readOp || (s_reg.bitIdx + 6'd1 < DRIVE_BITS_READ);
        end
      end
    end else begin
      s_next.halfCnt = s_reg.halfCnt + 6'd1;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    s_reg <= s_next;
  end

  //////////////////////
  // Outputs
  assign mgmt.done = s_reg.done;
  assign mgmt.rdWord = s_reg.rdWord;
  assign mgmt.mdc = s_reg.mdc;
  assign mgmt.mdioOut = s_reg.mdioOut;
  assign mgmt.mdioOe = s_reg.mdioOe;

endmodule

// *** hw/mmpc_top.sv ***
// MII management port control: registers, setup frames, pin tracking, loopback
`timescale 1ns/1ps
module mmpc_top
  import mmpc_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic softReset,
  input wire logic portScanActive,
  input wire logic [REG_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  input wire logic firstPollLoad,
  input wire logic [15:0] firstPollWord,
  output logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  output logic pinLevelChange,
  input wire logic [3:0] macTxd,
  input wire logic macTxEn,
  input wire logic macTxEr,
  output logic [3:0] macRxd,
  output logic macRxDv,
  output logic macRxEr,
  output logic macRxClk,
  output logic macCrs,
  output logic [3:0] phyTxd,
  output logic phyTxEn,
  output logic phyTxEr,
  input wire logic phyTxClk,
  input wire logic phyRxClk,
  input wire logic [3:0] phyRxd,
  input wire logic phyRxDv,
  input wire logic phyRxEr,
  input wire logic phyCrs
);

  //////////////////////
  // Types and state

  // Clock and receive pin group as sampled from the PHY
  typedef struct packed {
    logic txClk; // Transmit clock pin
    logic rxClk; // Receive clock pin
    logic [3:0] rxd; // Receive nibble
    logic rxDv; // Receive data valid
    logic rxEr; // Receive error
    logic crs; // Carrier sense
  } mmpc_phy_pins_s;

  typedef struct packed {
    logic [1:0] rate; // management_clock_rate
    logic phyResetOnStart; // phy_reset_on_start
    logic phyAutonegForce; // phy_autoneg_force
    logic phyFullDuplexForce; // phy_full_duplex_force
    logic phyFastSpeedForce; // phy_fast_speed_force
    logic internalLoopbackEnable; // internal_loopback_enable
    logic [4:0] targetPortNumber; // target_port_number
    logic [4:0] targetRegisterNumber; // target_register_number
    logic [15:0] managementDataWord; // management_data_word
    logic dataPinIdleLevel; // data_pin_idle_level
    logic levelChange; // Idle level change pulse
    mmpc_setup_e setup; // Setup frame sequence step
    logic frameActive; // A frame is launched and not yet done
    logic frameIsRead; // The launched frame is a read
    logic start; // Launch pulse to the engine
    logic [4:0] frameReg; // Register address of the launched frame
    logic [15:0] frameWord; // Write data of the launched frame
    logic [31:0] rdData; // Read data register
    logic mdioS1; // Data pin, first sync stage
    logic mdioS2; // Data pin, second sync stage
    mmpc_phy_pins_s phyS1; // PHY pins, first sync stage
    mmpc_phy_pins_s phyS2; // PHY pins, second sync stage
    logic [3:0] rxd; // Nibble to the MAC
    logic rxDv; // Valid to the MAC
    logic rxEr; // Error to the MAC
    logic rxClk; // Receive clock to the MAC
    logic crs; // Carrier to the MAC
    logic [3:0] txd; // Nibble to the PHY
    logic txEn; // Enable to the PHY
    logic txEr; // Error to the PHY
  } mmpc_top_s;

  mmpc_top_s s_reg; // Registered state
  mmpc_top_s s_next; // Next state

  mmpc_mgmt_if mgmt (); // Link to the frame engine

  // PHY control word for the mode setup frame
  function automatic logic [15:0] mode_word(input logic an, input logic fd,
      input logic sp);
    logic [15:0] w;
    w = '0;
    if (an) begin
      w = CTRL_AUTONEG_WORD;
    end else begin
      w[CTRL_SPEED_BIT] = sp;
      w[CTRL_DUPLEX_BIT] = fd;
    end
    return w;
  endfunction

  //////////////////////
  // Frame engine
  mmpc_frame_engine u_engine (
    .clock(clock),
    .reset(reset),
    .mgmt(mgmt)
  );

  assign mgmt.start = s_reg.start;
  assign mgmt.isRead = s_reg.frameIsRead;
  assign mgmt.portNum = s_reg.targetPortNumber;
  assign mgmt.regNum = s_reg.frameReg;
  assign mgmt.wrWord = s_reg.frameWord;
  assign mgmt.rate = s_reg.rate;
  assign mgmt.mdioIn = s_reg.mdioS2;

  //////////////////////
  // Next-state logic
  always_comb begin
    logic dataHit;
    logic hostWr;
    logic hostRd;
    logic [31:0] rd;
    dataHit = (regAddr == ADDR_MGMT_DATA);
    hostWr = regWrite && dataHit && !s_reg.frameActive;
    hostRd = regRead && dataHit && !s_reg.frameActive;
    rd = '0;
    s_next = s_reg;
    s_next.start = 1'b0;
    s_next.levelChange = 1'b0;

    // Pin synchronisers
    s_next.mdioS1 = mdioIn;
    s_next.mdioS2 = s_reg.mdioS1;
    s_next.phyS1 = {phyTxClk, phyRxClk, phyRxd, phyRxDv, phyRxEr, phyCrs};
    s_next.phyS2 = s_reg.phyS1;

    // Register writes to control and target fields
    if (regWrite && regAddr == ADDR_CONTROL_STATUS) begin
      s_next.rate = regWrData[POS_RATE_LO +: 2];
      s_next.phyResetOnStart = regWrData[POS_PHY_RESET];
      s_next.phyAutonegForce = regWrData[POS_AUTONEG];
      s_next.phyFullDuplexForce = regWrData[POS_DUPLEX];
      s_next.phyFastSpeedForce = regWrData[POS_SPEED];
      s_next.internalLoopbackEnable = regWrData[POS_LOOPBACK];
    end
    if (regWrite && regAddr == ADDR_TARGET_SELECT) begin
      s_next.targetPortNumber = regWrData[POS_PORT_LO +: 5];
      s_next.targetRegisterNumber = regWrData[POS_REGNUM_LO +: 5];
    end
    if (firstPollLoad) begin
      s_next.targetPortNumber = firstPollWord[POS_PORT_LO +: 5];
    end

    // Host launches first; refused while busy
    if (hostWr) begin
      s_next.managementDataWord = regWrData[15:0];
      s_next.frameWord = regWrData[15:0];
      s_next.frameReg = s_reg.targetRegisterNumber;
      s_next.frameIsRead = 1'b0;
      s_next.frameActive = 1'b1;
      s_next.start = 1'b1;
    end else if (hostRd) begin
      s_next.frameReg = s_reg.targetRegisterNumber;
      s_next.frameIsRead = 1'b1;
      s_next.frameActive = 1'b1;
      s_next.start = 1'b1;
    end else if (!s_reg.frameActive && portScanActive) begin
      // Setup frames toward the PHY control register
      case (s_reg.setup)
        SU_RESET: begin
          if (s_reg.phyResetOnStart) begin
            s_next.frameWord = CTRL_RESET_WORD;
            s_next.frameReg = PHY_CTRL_REG;
            s_next.frameIsRead = 1'b0;
            s_next.frameActive = 1'b1;
            s_next.start = 1'b1;
          end
          s_next.setup = SU_MODE;
        end
        SU_MODE: begin
          s_next.frameWord = mode_word(s_reg.phyAutonegForce,
            s_reg.phyFullDuplexForce, s_reg.phyFastSpeedForce);
          s_next.frameReg = PHY_CTRL_REG;
          s_next.frameIsRead = 1'b0;
          s_next.frameActive = 1'b1;
          s_next.start = 1'b1;
          s_next.setup = SU_IDLE;
        end
        default: begin
          s_next.setup = SU_IDLE;
        end
      endcase
    end

    // Frame end: a read stores the PHY word
    if (mgmt.done) begin
      s_next.frameActive = 1'b0;
      if (s_reg.frameIsRead) begin
        s_next.managementDataWord = mgmt.rdWord;
      end
    end

    // Idle level follows the pin only between frames
    if (!s_reg.frameActive) begin
      s_next.dataPinIdleLevel = s_reg.mdioS2;
      s_next.levelChange = (s_reg.mdioS2 != s_reg.dataPinIdleLevel);
    end

    // Register read, answered in the next cycle
    if (regRead) begin
      case (regAddr)
        ADDR_CONTROL_STATUS: begin
          rd[POS_BUSY] = s_reg.frameActive;
          rd[POS_IDLE_LEVEL] = s_reg.dataPinIdleLevel;
          rd[POS_RATE_LO +: 2] = s_reg.rate;
          rd[POS_PHY_RESET] = s_reg.phyResetOnStart;
          rd[POS_AUTONEG] = s_reg.phyAutonegForce;
          rd[POS_DUPLEX] = s_reg.phyFullDuplexForce;
          rd[POS_SPEED] = s_reg.phyFastSpeedForce;
          rd[POS_LOOPBACK] = s_reg.internalLoopbackEnable;
        end
        ADDR_TARGET_SELECT: begin
          rd[POS_PORT_LO +: 5] = s_reg.targetPortNumber;
          rd[POS_REGNUM_LO +: 5] = s_reg.targetRegisterNumber;
        end
        ADDR_MGMT_DATA: begin
          rd[15:0] = s_reg.managementDataWord;
        end
        default: begin
          rd = '0;
        end
      endcase
    end
    s_next.rdData = rd;

    // MII data path, with the internal loopback
    if (s_reg.internalLoopbackEnable) begin
      s_next.rxd = macTxd;
      s_next.rxDv = macTxEn;
      s_next.rxEr = macTxEr;
      s_next.rxClk = s_reg.phyS2.txClk;
      s_next.crs = s_reg.phyS2.crs | macTxEn | s_reg.rxDv;
      s_next.txEn = 1'b0;
      s_next.txd = '0;
    end else begin
      s_next.rxd = s_reg.phyS2.rxd;
      s_next.rxDv = s_reg.phyS2.rxDv;
      s_next.rxEr = s_reg.phyS2.rxEr;
      s_next.rxClk = s_reg.phyS2.rxClk;
      s_next.crs = s_reg.phyS2.crs;
      s_next.txEn = macTxEn;
      s_next.txd = macTxd;
    end
    s_next.txEr = 1'b0;

    // Soft reset reruns setup, keeps fields
    if (softReset) begin
      s_next.setup = SU_RESET;
    end

    // Hard reset clears the control bits
    if (reset) begin
      s_next = '0;
      s_next.rate = RST_RATE;
      s_next.phyResetOnStart = RST_BIT;
      s_next.internalLoopbackEnable = RST_BIT;
      s_next.managementDataWord = RST_WORD;
      s_next.setup = SU_RESET;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    s_reg <= s_next;
  end

  //////////////////////
  // Outputs
  assign regRdData = s_reg.rdData;
  assign mdc = mgmt.mdc;
  assign mdioOut = mgmt.mdioOut;
  assign mdioOe = mgmt.mdioOe;
  assign pinLevelChange = s_reg.levelChange;
  assign macRxd = s_reg.rxd;
  assign macRxDv = s_reg.rxDv;
  assign macRxEr = s_reg.rxEr;
  assign macRxClk = s_reg.rxClk;
  assign macCrs = s_reg.crs;
  assign phyTxd = s_reg.txd;
  assign phyTxEn = s_reg.txEn;
  assign phyTxEr = s_reg.txEr;

endmodule

// *** tb/mmpc_top_props.sv ***
// Concurrent checks on the ports of the MII management port control block
`timescale 1ns/1ps
module mmpc_top_props
  import mmpc_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [REG_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdData,
  input wire logic mdc,
  input wire logic mdioOe,
  input wire logic pinLevelChange,
  input wire logic [3:0] macTxd,
  input wire logic macTxEn,
  input wire logic macTxEr,
  input wire logic [3:0] macRxd,
  input wire logic macRxDv,
  input wire logic macRxEr,
  input wire logic macCrs,
  input wire logic phyTxEn,
  input wire logic phyTxEr
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  //////////////////////
  logic loopReg; // Loopback mirror
  logic [1:0] rateReg; // Rate mirror
  logic [5:0] lowCnt; // Cycles with clock low
  logic quiet; // Engine idle: clock low past a full bit of the slowest rate
  assign quiet = lowCnt > 6'h2D;
  // Control mirror and quiet time
  always_ff @(posedge clock) begin
    if (reset) begin
      loopReg <= 1'b0;
      rateReg <= 2'h0;
      lowCnt <= 6'h0;
    end else begin
      if (regWrite && regAddr == ADDR_CONTROL_STATUS) begin
        loopReg <= regWrData[POS_LOOPBACK];
        rateReg <= regWrData[POS_RATE_LO +: 2];
      end
      lowCnt <= mdc ? 6'h0 : (lowCnt == 6'h3F ? lowCnt : lowCnt + 6'h1);
    end
  end
  //////////////////////
  // Drive follows launch
  sequence sLaunch;
    ##[1:3] mdioOe;
  endsequence
  // Five-cycle high half
  sequence sHighHalf;
    mdc [*5] ##1 !mdc;
  endsequence
  chk_txer_zero: assert property (phyTxEr == 1'b0)
    else $error("transmit error output driven");
  chk_rd_stands: assert property (!regRead |=> regRdData == 32'h0)
    else $error("read data outside its cycle");
  chk_target_rsvd: assert property (regRead && regAddr == ADDR_TARGET_SELECT
    |=> regRdData[31:10] == 22'h0)
    else $error("target select reserved bits set");
  chk_wr_launch: assert property (regWrite && regAddr == ADDR_MGMT_DATA && quiet
    |-> sLaunch)
    else $error("data write launched no frame");
  chk_rd_launch: assert property (regRead && regAddr == ADDR_MGMT_DATA && quiet
    |-> sLaunch)
    else $error("data read launched no frame");
  chk_loop_data: assert property (loopReg |=> macRxd == $past(macTxd))
    else $error("loopback nibble wrong");
  chk_loop_ctrl: assert property (loopReg
    |=> macRxDv == $past(macTxEn) && macRxEr == $past(macTxEr))
    else $error("loopback valid or error wrong");
  chk_loop_crs: assert property (loopReg && macTxEn |=> macCrs && !phyTxEn)
    else $error("loopback carrier missing");
  chk_mdc_half: assert property ($rose(mdc) && rateReg == 2'h2 |-> sHighHalf)
    else $error("management clock half period wrong");
  chk_pin_hold: assert property (mdioOe |-> !pinLevelChange)
    else $error("idle level change during frame");
endmodule
bind mmpc_top mmpc_top_props u_mmpc_top_props (
  .clock(clock), .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
  .regRead(regRead), .regRdData(regRdData), .mdc(mdc), .mdioOe(mdioOe),
  .pinLevelChange(pinLevelChange), .macTxd(macTxd), .macTxEn(macTxEn), .macTxEr(macTxEr),
  .macRxd(macRxd), .macRxDv(macRxDv), .macRxEr(macRxEr), .macCrs(macCrs), .phyTxEn(phyTxEn),
  .phyTxEr(phyTxEr)
);

// *** tb/mmpc_phy_model.sv ***
// Behavioural PHY answering management frames on the data line
`timescale 1ns/1ps
module mmpc_phy_model #(
  parameter logic [4:0] PORT = 5'h03
) (
  input wire logic reset,
  input wire logic mdc,
  input wire logic mdioWire,
  output logic phyOe,
  output logic phyDq,
  output logic [63:0] frame,
  output int frames
);
  // Bits seen, newest in bit 0
  logic [63:0] sh;
  // Bit position within the frame
  logic [5:0] cnt;
  // Word being returned by a read
  logic [15:0] rd;
  // PHY registers
  logic [15:0] mem [32];
  wire [63:0] f = {sh[62:0], mdioWire};
  // Known register pattern
  initial begin
    frames = 0;
    for (int i = 0; i < 32; i++) mem[i] = 16'hC0DE ^ 16'(i);
  end
  // Sample on rising clock, store writes at end
  always @(posedge mdc or posedge reset) begin
    if (reset) begin
      cnt <= 6'h0;
    end else begin
      sh <= f;
      cnt <= cnt + 6'h1;
      if (cnt == 6'h3F) begin
        frame <= f;
        frames <= frames + 1;
        if (f[29:28] == 2'b01 && f[27:23] == PORT) mem[f[22:18]] <= f[15:0];
      end
    end
  end
  // Answer reads: turnaround zero, data MSB first
  always @(negedge mdc or posedge reset) begin
    if (reset) begin
      phyOe <= 1'b0;
    end else if (cnt == 6'h2F && sh[12:11] == 2'b10 && sh[10:6] == PORT) begin
      rd <= mem[sh[5:1]];
      phyOe <= 1'b1;
      phyDq <= 1'b0;
    end else if (phyOe && cnt >= 6'h30) begin
      phyDq <= rd[6'h3F - cnt];
    end else begin
      phyOe <= 1'b0;
    end
  end
endmodule

// *** tb/tb_top.sv ***
// Self-checking testbench for the MII management port control block
`timescale 1ns/1ps
module tb_top;
  import mmpc_pkg::*;
  logic clock, reset, softReset, portScanActive, regWrite, regRead, firstPollLoad, phyTxClk;
  logic [REG_ADDR_W-1:0] regAddr;
  logic [31:0] regWrData, regRdData;
  logic [15:0] firstPollWord;
  logic [3:0] macTxd, macRxd, phyTxd;
  logic macTxEn, macTxEr, macRxDv, macRxEr, macRxClk, macCrs, phyTxEn, phyTxEr;
  logic mdc, mdioOut, mdioOe, pinLevelChange, phyOe, phyDq, mdioWire;
  logic [63:0] frame;
  int frames, fail_count, n_tests;
  // Pulled-up shared data line
  assign mdioWire = mdioOe ? mdioOut : (phyOe ? phyDq : 1'b1);
  mmpc_top u_mmpc_top (
    .clock(clock), .reset(reset), .softReset(softReset), .portScanActive(portScanActive),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .firstPollLoad(firstPollLoad), .firstPollWord(firstPollWord),
    .mdc(mdc), .mdioIn(mdioWire), .mdioOut(mdioOut), .mdioOe(mdioOe),
    .pinLevelChange(pinLevelChange), .macTxd(macTxd), .macTxEn(macTxEn), .macTxEr(macTxEr),
    .macRxd(macRxd), .macRxDv(macRxDv), .macRxEr(macRxEr), .macRxClk(macRxClk),
    .macCrs(macCrs), .phyTxd(phyTxd), .phyTxEn(phyTxEn), .phyTxEr(phyTxEr),
    .phyTxClk(phyTxClk), .phyRxClk(1'b0), .phyRxd(4'h0), .phyRxDv(1'b0), .phyRxEr(1'b0),
    .phyCrs(1'b0)
  );
  mmpc_phy_model u_mmpc_phy_model (
    .reset(reset), .mdc(mdc), .mdioWire(mdioWire), .phyOe(phyOe), .phyDq(phyDq),
    .frame(frame), .frames(frames)
  );
  //////////////////////
  // Clock at 100 MHz
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Slow transmit clock
  always #20 phyTxClk = ~phyTxClk;
  // Compare and count
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One-cycle register write
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  // One-cycle read, data taken next cycle
  task automatic rd(logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask
  // Bounded busy poll
  task automatic waitIdle;
    logic [31:0] v;
    for (int i = 0; i < 1000; i++) begin
      rd(ADDR_CONTROL_STATUS, v);
      if (v[POS_BUSY] === 1'b0) break;
    end
    check("idle", 32'(v[POS_BUSY]), 32'h0);
  endtask
  // Bounded wait for PHY frames
  task automatic waitFrames(int n);
    for (int i = 0; i < 3000 && frames < n; i++) @(posedge clock);
    check("frameSeen", 32'(frames >= n), 32'h1);
  endtask
  // Frame check
  task automatic chkFrame(logic [1:0] op, logic [4:0] pn, logic [4:0] rn, logic [15:0] d);
    check("preamble", frame[63:32], 32'hFFFF_FFFF);
    check("fields", {16'h0, frame[31:16]}, {16'h0, 2'b01, op, pn, rn, 2'b10});
    check("data", {16'h0, frame[15:0]}, {16'h0, d});
  endtask
  //////////////////////
  // Reset values, access, unmapped index
  task automatic t_regs;
    logic [31:0] v;
    repeat (5) @(posedge clock);
    rd(ADDR_CONTROL_STATUS, v);
    check("ctrlReset", {16'h0, v[15:0] & 16'hBFFF}, 32'h0);
    check("idleLevel", 32'(v[POS_IDLE_LEVEL]), 32'h1);
    wr(ADDR_TARGET_SELECT, 32'hFFFF_F86A);
    rd(ADDR_TARGET_SELECT, v);
    check("target", v, 32'h0000_006A);
    wr(4'h3, 32'hFFFF_FFFF);
    rd(4'h3, v);
    check("unmapped", v, 32'h0);
    wr(ADDR_CONTROL_STATUS, 32'h0000_2002);
    rd(ADDR_CONTROL_STATUS, v);
    check("ctrl", {16'h0, v[15:0] & 16'hBFFF}, 32'h0000_2002);
    wr(ADDR_CONTROL_STATUS, 32'h0000_2000);
    $display("test t_regs done");
  endtask
  // Write frame, with a second write refused while busy
  task automatic t_write;
    int f0;
    f0 = frames;
    repeat (50) @(posedge clock);
    wr(ADDR_MGMT_DATA, 32'h0000_A5C3);
    wr(ADDR_MGMT_DATA, 32'h0000_1111);
    waitIdle();
    check("oneFrame", 32'(frames - f0), 32'h1);
    chkFrame(OP_WRITE, 5'h03, 5'h0A, 16'hA5C3);
    $display("test t_write done");
  endtask
  // Read frame: old word, then PHY word
  task automatic t_read;
    logic [31:0] v;
    wr(ADDR_TARGET_SELECT, 32'h0000_0067);
    repeat (50) @(posedge clock);
    rd(ADDR_MGMT_DATA, v);
    check("oldWord", v, 32'h0000_A5C3);
    waitIdle();
    chkFrame(OP_READ, 5'h03, 5'h07, 16'hC0D9);
    rd(ADDR_MGMT_DATA, v);
    check("phyWord", v, 32'h0000_C0D9);
    waitIdle();
    $display("test t_read done");
  endtask
  // Loopback on and off
  task automatic t_loop;
    wr(ADDR_CONTROL_STATUS, 32'h0000_2002);
    @(posedge clock);
    macTxd <= 4'h9;
    macTxEn <= 1'b1;
    macTxEr <= 1'b1;
    repeat (2) @(posedge clock);
    #1 check("loop", {23'h0, macRxd, macRxDv, macRxEr, macCrs, phyTxEn, phyTxEr}, 32'h13C);
    wr(ADDR_CONTROL_STATUS, 32'h0000_2000);
    @(posedge clock);
    macTxd <= 4'h6;
    repeat (2) @(posedge clock);
    #1 check("direct", {25'h0, phyTxd, phyTxEn, phyTxEr, macRxDv}, 32'h0000_0034);
    macTxEn <= 1'b0;
    macTxEr <= 1'b0;
    $display("test t_loop done");
  endtask
  // Setup frames after soft reset, only while scanning
  task automatic t_setup;
    int f0;
    logic [31:0] v;
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_CONTROL_STATUS, i ? 32'h0000_2060 : 32'h0000_2058);
      f0 = frames;
      @(posedge clock);
      softReset <= 1'b1;
      @(posedge clock);
      softReset <= 1'b0;
      repeat (50) @(posedge clock);
      check("noScan", 32'(frames - f0), 32'h0);
      portScanActive <= 1'b1;
      waitFrames(f0 + 1);
      chkFrame(OP_WRITE, 5'h03, PHY_CTRL_REG, CTRL_RESET_WORD);
      waitFrames(f0 + 2);
      chkFrame(OP_WRITE, 5'h03, PHY_CTRL_REG, i ? CTRL_AUTONEG_WORD : 16'h2100);
      portScanActive <= 1'b0;
      waitIdle();
    end
    rd(ADDR_MGMT_DATA, v);
    check("keptWord", v, 32'h0000_C0D9);
    $display("test t_setup done");
  endtask
  // Poll setup load, then hard reset
  task automatic t_hard;
    logic [31:0] v;
    @(posedge clock);
    firstPollWord <= 16'h02A0;
    firstPollLoad <= 1'b1;
    @(posedge clock);
    firstPollLoad <= 1'b0;
    rd(ADDR_TARGET_SELECT, v);
    check("pollPort", v, 32'h0000_02A7);
    @(posedge clock);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    rd(ADDR_CONTROL_STATUS, v);
    check("hardCtrl", {16'h0, v[15:0] & 16'hBFFF}, 32'h0);
    $display("test t_hard done");
  endtask
  //////////////////////
  // Counts and verdict
  task automatic final_report;
    $display("Checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (30000) @(posedge clock);
    fail_count++;
    final_report();
  end
  // Main sequence
  initial begin
    {softReset, portScanActive, regWrite, regRead, firstPollLoad, phyTxClk} = 6'h0;
    {macTxEn, macTxEr, macTxd, regAddr, regWrData, firstPollWord} = 0;
    reset = 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    t_regs();
    t_write();
    t_read();
    t_loop();
    t_setup();
    t_hard();
    final_report();
  end
endmodule
